/* File: src/lamp_pkg.sv */
`default_nettype none
package lamp_pkg;
    // system clock and lamp blink timebase
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 500;
    localparam int unsigned TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 32;

    // register byte offsets
    localparam logic [7:0] COND_OFFSET = 8'h00;
    localparam logic [7:0] LAMP_OFFSET = 8'h04;

    // condition register layout
    localparam int unsigned COND_W = 18;
    localparam logic [COND_W-1:0] COND_RESET = 18'h00000;
    localparam logic [COND_W-1:0] COND_MASK = 18'h337FF;
    localparam int unsigned C_RUN = 0;
    localparam int unsigned C_HW_UPDATE = 1;
    localparam int unsigned C_STORAGE = 2;
    localparam int unsigned C_OVERTEMP = 3;
    localparam int unsigned C_HEALTH_OK = 4;
    localparam int unsigned C_HALT = 5;
    localparam int unsigned C_SECURE_ERR = 6;
    localparam int unsigned C_SCAN_EN = 7;
    localparam int unsigned C_OVERRIDE = 8;
    localparam int unsigned C_FATAL = 9;
    localparam int unsigned C_FIELDBUS_OK = 10;
    localparam int unsigned C_AGENT = 12;
    localparam int unsigned C_POWER = 16;

    // cloud agent and power states, two-bit fields
    localparam logic [1:0] AGENT_OFF = 2'h0;
    localparam logic [1:0] AGENT_STARTING = 2'h1;
    localparam logic [1:0] AGENT_RUNNING = 2'h2;
    localparam logic [1:0] AGENT_CONNECTED = 2'h3;
    localparam logic [1:0] PWR_ABSENT = 2'h0;
    localparam logic [1:0] PWR_BOOT = 2'h1;
    localparam logic [1:0] PWR_RUNNING = 2'h2;
    localparam logic [1:0] PWR_OFF = 2'h3;

    // lamp vector bit positions, also the lamp readback layout
    localparam int unsigned LAMP_N = 14;
    localparam int unsigned L_MODE = 0;
    localparam int unsigned L_PRESENCE = 1;
    localparam int unsigned L_STORAGE = 2;
    localparam int unsigned L_OVERHEAT = 3;
    localparam int unsigned L_HEALTH = 4;
    localparam int unsigned L_SCAN = 5;
    localparam int unsigned L_OVERRIDE = 6;
    localparam int unsigned L_FATAL = 7;
    localparam int unsigned L_FIELDBUS = 8;
    localparam int unsigned L_ACTIVE = 9;
    localparam int unsigned L_BACKUP = 10;
    localparam int unsigned L_AGENT = 11;
    localparam int unsigned L_PWR_GREEN = 12;
    localparam int unsigned L_PWR_RED = 13;
    localparam int unsigned PHASE_POS = 16;

    typedef struct packed {
        logic [COND_W-1:0] cond;
        logic [CNT_W-1:0] tick_cnt;
        logic [1:0] phase;
        logic [LAMP_N-1:0] lamps;
        logic ack;
        logic [31:0] rdata;
    } lamp_state_t;
endpackage
`default_nettype wire

/* File: src/front_panel_status_lamps.sv */
// Overview of operation
// R1: the mode lamp is steady green in run mode and dark in stop mode.
// R2: while hardware is being reprogrammed, mode and scan lamps blink in phase.
// R3: the presence lamp is always dark.
// R4: the storage activity lamp is green while disk activity is seen.
// R5: the overheat lamp is steady red while overtemperature is seen.
// R6: the health lamp is steady green once diagnostics pass, else dark.
// R7: in the halt state the health lamp blinks and every other lamp is dark.
// R8: on a secure boot error health and scan lamps blink in alternation.
// R9: the scan lamp is steady green while output scanning is enabled.
// R10: the override lamp is steady yellow while any override is active.
// R11: the fatal fault lamp is steady red after a fatal fault.
// R12: the fieldbus lamp is green while the fieldbus connection is good.
// R13: the active unit and backup unit lamps are always dark.
// R14: the cloud agent lamp blinks 0.5 Hz starting, 1 Hz running, is steady
//      when connected and dark when off.
// R15: the power lamp blinks green booting, is green running, red when off
//      and dark in reset or without power.
// R16: all blinking comes from one divided timebase and reset darkens lamps.
`default_nettype none
module front_panel_status_lamps
    import lamp_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mode_lamp_green_o,
    output logic presence_lamp_o,
    output logic storage_activity_lamp_o,
    output logic overheat_lamp_red_o,
    output logic health_lamp_green_o,
    output logic output_scan_lamp_green_o,
    output logic override_lamp_o,
    output logic fatal_fault_lamp_o,
    output logic fieldbus_lamp_green_o,
    output logic active_unit_lamp_o,
    output logic backup_unit_lamp_o,
    output logic cloud_agent_lamp_o,
    output logic power_lamp_green_o,
    output logic power_lamp_red_o
);

    if (TICK_LEN < 2)
    begin : g_bad_tick
        $error("TICK_LEN must be at least 2");
    end

    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_LEN - 1);

    lamp_state_t s_q;
    lamp_state_t s_d;
    logic blink_fast;
    logic blink_slow;
    logic req;
    logic [31:0] wr_merged;

    // phase bit 0 gives 1 Hz, bit 1 gives 0.5 Hz, both from one counter
    assign blink_fast = s_q.phase[0]; // see R16
    assign blink_slow = s_q.phase[1]; // see R16
    // the ack term keeps a held request from being answered twice
    assign req = wb_cyc_i && wb_stb_i && !s_q.ack;

    always_comb
    begin
        wr_merged = 32'h00000000;
        wr_merged[COND_W-1:0] = s_q.cond;
        for (int i = 0; i < 4; i++)
        begin
            if (wb_sel_i[i])
            begin
                wr_merged[8*i +: 8] = wb_dat_i[8*i +: 8];
            end
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.ack = req;

        if (s_q.tick_cnt == TICK_LAST)
        begin
            s_d.tick_cnt = '0;
            s_d.phase = s_q.phase + 2'h1;
        end
        else
        begin
            s_d.tick_cnt = s_q.tick_cnt + CNT_W'(1);
        end

        // commit on the edge at which the master samples ack, while it
        // still holds address, lanes and data
        if (wb_cyc_i && wb_stb_i && s_q.ack && wb_we_i
            && wb_adr_i == COND_OFFSET)
        begin
            s_d.cond = wr_merged[COND_W-1:0] & COND_MASK;
        end
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                COND_OFFSET: s_d.rdata = {14'h0000, s_q.cond};
                LAMP_OFFSET: s_d.rdata = {14'h0000, s_q.phase,
                                          2'h0, s_q.lamps};
                default: s_d.rdata = 32'h00000000;
            endcase
        end

        // presence, active and backup lamps are never set
        s_d.lamps = '0; // see R3, R13
        if (s_q.cond[C_HALT])
        begin
            s_d.lamps[L_HEALTH] = blink_fast; // see R7
        end
        else
        begin
            s_d.lamps[L_MODE] = s_q.cond[C_HW_UPDATE] ? blink_fast
                : s_q.cond[C_RUN]; // see R1, R2
            s_d.lamps[L_SCAN] = s_q.cond[C_HW_UPDATE] ? blink_fast
                : s_q.cond[C_SCAN_EN]; // see R2, R9
            s_d.lamps[L_HEALTH] = s_q.cond[C_HEALTH_OK]; // see R6
            // a boot error outranks reprogramming on the scan lamp
            if (s_q.cond[C_SECURE_ERR])
            begin
                s_d.lamps[L_HEALTH] = blink_fast; // see R8
                s_d.lamps[L_SCAN] = !blink_fast; // see R8
            end
            s_d.lamps[L_STORAGE] = s_q.cond[C_STORAGE]; // see R4
            s_d.lamps[L_OVERHEAT] = s_q.cond[C_OVERTEMP]; // see R5
            s_d.lamps[L_OVERRIDE] = s_q.cond[C_OVERRIDE]; // see R10
            s_d.lamps[L_FATAL] = s_q.cond[C_FATAL]; // see R11
            s_d.lamps[L_FIELDBUS] = s_q.cond[C_FIELDBUS_OK]; // see R12
            case (s_q.cond[C_AGENT +: 2])
                AGENT_STARTING: s_d.lamps[L_AGENT] = blink_slow; // see R14
                AGENT_RUNNING: s_d.lamps[L_AGENT] = blink_fast; // see R14
                AGENT_CONNECTED: s_d.lamps[L_AGENT] = 1'b1; // see R14
                default: s_d.lamps[L_AGENT] = 1'b0;
            endcase
            case (s_q.cond[C_POWER +: 2])
                PWR_BOOT: s_d.lamps[L_PWR_GREEN] = blink_fast; // see R15
                PWR_RUNNING: s_d.lamps[L_PWR_GREEN] = 1'b1; // see R15
                PWR_OFF: s_d.lamps[L_PWR_RED] = 1'b1; // see R15
                default: s_d.lamps[L_PWR_GREEN] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q <= '0; // see R16
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign mode_lamp_green_o = s_q.lamps[L_MODE];
    assign presence_lamp_o = s_q.lamps[L_PRESENCE];
    assign storage_activity_lamp_o = s_q.lamps[L_STORAGE];
    assign overheat_lamp_red_o = s_q.lamps[L_OVERHEAT];
    assign health_lamp_green_o = s_q.lamps[L_HEALTH];
    assign output_scan_lamp_green_o = s_q.lamps[L_SCAN];
    assign override_lamp_o = s_q.lamps[L_OVERRIDE];
    assign fatal_fault_lamp_o = s_q.lamps[L_FATAL];
    assign fieldbus_lamp_green_o = s_q.lamps[L_FIELDBUS];
    assign active_unit_lamp_o = s_q.lamps[L_ACTIVE];
    assign backup_unit_lamp_o = s_q.lamps[L_BACKUP];
    assign cloud_agent_lamp_o = s_q.lamps[L_AGENT];
    assign power_lamp_green_o = s_q.lamps[L_PWR_GREEN];
    assign power_lamp_red_o = s_q.lamps[L_PWR_RED];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic live;
    assign live = !s_q.cond[C_HALT];

    property p_run_mode;
        live && !s_q.cond[C_HW_UPDATE]
            |=> mode_lamp_green_o == $past(s_q.cond[C_RUN]);
    endproperty
    a_run_mode: assert property (p_run_mode) // see R1
        else $error("mode lamp does not follow run mode");

    property p_update_in_phase;
        live && s_q.cond[C_HW_UPDATE] && !s_q.cond[C_SECURE_ERR]
            |=> mode_lamp_green_o == output_scan_lamp_green_o;
    endproperty
    a_update_in_phase: assert property (p_update_in_phase) // see R2
        else $error("mode and scan lamps not in phase");

    property p_dark_spares;
        !presence_lamp_o && !active_unit_lamp_o && !backup_unit_lamp_o;
    endproperty
    a_dark_spares: assert property (p_dark_spares) // see R3, R13
        else $error("unused lamp lit");

    property p_overheat;
        live |=> overheat_lamp_red_o == $past(s_q.cond[C_OVERTEMP]);
    endproperty
    a_overheat: assert property (p_overheat) // see R5
        else $error("overheat lamp wrong");

    property p_storage;
        live |=> storage_activity_lamp_o == $past(s_q.cond[C_STORAGE]);
    endproperty
    a_storage: assert property (p_storage) // see R4
        else $error("storage lamp wrong");

    property p_health_steady;
        live && !s_q.cond[C_SECURE_ERR]
            |=> health_lamp_green_o == $past(s_q.cond[C_HEALTH_OK]);
    endproperty
    a_health_steady: assert property (p_health_steady) // see R6
        else $error("health lamp wrong");

    property p_scan_steady;
        live && !s_q.cond[C_HW_UPDATE] && !s_q.cond[C_SECURE_ERR]
            |=> output_scan_lamp_green_o == $past(s_q.cond[C_SCAN_EN]);
    endproperty
    a_scan_steady: assert property (p_scan_steady) // see R9
        else $error("scan lamp wrong");

    property p_override;
        live |=> override_lamp_o == $past(s_q.cond[C_OVERRIDE]);
    endproperty
    a_override: assert property (p_override) // see R10
        else $error("override lamp wrong");

    property p_fatal;
        live |=> fatal_fault_lamp_o == $past(s_q.cond[C_FATAL]);
    endproperty
    a_fatal: assert property (p_fatal) // see R11
        else $error("fatal fault lamp wrong");

    property p_fieldbus;
        live |=> fieldbus_lamp_green_o == $past(s_q.cond[C_FIELDBUS_OK]);
    endproperty
    a_fieldbus: assert property (p_fieldbus) // see R12
        else $error("fieldbus lamp wrong");

    property p_reset_dark;
        $past(rst_i) |-> s_q.lamps == '0;
    endproperty
    a_reset_dark: assert property (p_reset_dark) // see R16
        else $error("lamps lit straight after reset");

    property p_halt_dark;
        s_q.cond[C_HALT] |=> !mode_lamp_green_o && !output_scan_lamp_green_o
            && !fatal_fault_lamp_o && !cloud_agent_lamp_o
            && !power_lamp_green_o && !power_lamp_red_o
            && health_lamp_green_o == $past(blink_fast);
    endproperty
    a_halt_dark: assert property (p_halt_dark) // see R7
        else $error("halt does not darken lamps");

    property p_secure_alt;
        live && s_q.cond[C_SECURE_ERR]
            |=> health_lamp_green_o != output_scan_lamp_green_o;
    endproperty
    a_secure_alt: assert property (p_secure_alt) // see R8
        else $error("boot error lamps not alternating");

    property p_agent_connected;
        live && s_q.cond[C_AGENT +: 2] == AGENT_CONNECTED
            |=> cloud_agent_lamp_o;
    endproperty
    a_agent_connected: assert property (p_agent_connected) // see R14
        else $error("agent lamp dark while connected");

    property p_power_off_red;
        live && s_q.cond[C_POWER +: 2] == PWR_OFF
            |=> power_lamp_red_o && !power_lamp_green_o;
    endproperty
    a_power_off_red: assert property (p_power_off_red) // see R15
        else $error("power lamp not red in off state");

    property p_slow_half_fast;
        $rose(blink_slow) |-> $past(blink_fast) && !blink_fast;
    endproperty
    a_slow_half_fast: assert property (p_slow_half_fast) // see R16
        else $error("slow blink not derived from fast blink");

    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("bus ack not a single cycle");

    c_halt: cover property (s_q.cond[C_HALT] ##1 health_lamp_green_o);
    c_secure: cover property (live && s_q.cond[C_SECURE_ERR]
                              ##1 output_scan_lamp_green_o);
    c_write: cover property (wb_ack_o && wb_we_i);
endmodule
`default_nettype wire

/* File: test/lamp_viewer.sv */
`default_nettype none
// operator watching the panel: counts lamp flips since the last clear
module lamp_viewer
    import lamp_pkg::*;
(
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [13:0] lamps_i,
    output logic [4:0] flips_o [14],
    output logic sync_break_o,
    output logic alt_break_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] last_q;

    always_ff @(posedge clk_i)
    begin
        last_q <= lamps_i;
        sync_break_o <= !clr_i && (sync_break_o ||
            lamps_i[L_MODE] != lamps_i[L_SCAN]);
        alt_break_o <= !clr_i && (alt_break_o ||
            lamps_i[L_HEALTH] == lamps_i[L_SCAN]);
        for (int i = 0; i < 14; i++)
        begin
            flips_o[i] <= clr_i ? 5'h00 :
                flips_o[i] + 5'(lamps_i[i] != last_q[i]);
        end
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`default_nettype none
module testbench
    import lamp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic clr = 1'b1;
    logic [31:0] rdat;
    logic ack;
    logic sb;
    logic ab;
    wire logic [13:0] lamps;
    logic [4:0] flips [14];
    logic [17:0] cur = 18'h0;
    int error_cnt = 0;
    int tests_run = 0;

    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // short timebase: 1 Hz blink flips every 4 cycles, 0.5 Hz every 8
    front_panel_status_lamps #(.TICK_LEN(4)) u_front_panel_status_lamps (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .mode_lamp_green_o(lamps[0]),
        .presence_lamp_o(lamps[1]), .storage_activity_lamp_o(lamps[2]),
        .overheat_lamp_red_o(lamps[3]), .health_lamp_green_o(lamps[4]),
        .output_scan_lamp_green_o(lamps[5]), .override_lamp_o(lamps[6]),
        .fatal_fault_lamp_o(lamps[7]), .fieldbus_lamp_green_o(lamps[8]),
        .active_unit_lamp_o(lamps[9]), .backup_unit_lamp_o(lamps[10]),
        .cloud_agent_lamp_o(lamps[11]), .power_lamp_green_o(lamps[12]),
        .power_lamp_red_o(lamps[13]));
    lamp_viewer u_lamp_viewer (.clk_i(clk_i), .clr_i(clr), .lamps_i(lamps),
        .flips_o(flips), .sync_break_o(sb), .alt_break_o(ab));

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_reg(input string n, input logic [31:0] e,
        input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        // no local limit: only the watchdog ends a wait for ack
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1);
        // ack comes one edge after the taking edge
        chk_reg("ack latency", 32'h2, n);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // lamp codes: 0 dark, 1 steady, 2 blink 1 Hz, 3 blink 0.5 Hz
    function automatic logic [13:0][1:0] exp_codes(input logic [17:0] c);
        logic [13:0][1:0] e;
        logic [1:0] ag;
        logic [1:0] pw;
        ag = c[C_AGENT+:2];
        pw = c[C_POWER+:2];
        e = '0;
        e[L_MODE] = c[C_HW_UPDATE] ? 2'h2 : {1'b0, c[C_RUN]};
        e[L_STORAGE] = {1'b0, c[C_STORAGE]};
        e[L_OVERHEAT] = {1'b0, c[C_OVERTEMP]};
        e[L_HEALTH] = c[C_SECURE_ERR] ? 2'h2 : {1'b0, c[C_HEALTH_OK]};
        e[L_SCAN] = (c[C_SECURE_ERR] || c[C_HW_UPDATE]) ? 2'h2 :
            {1'b0, c[C_SCAN_EN]};
        e[L_OVERRIDE] = {1'b0, c[C_OVERRIDE]};
        e[L_FATAL] = {1'b0, c[C_FATAL]};
        e[L_FIELDBUS] = {1'b0, c[C_FIELDBUS_OK]};
        e[L_AGENT] = ag == AGENT_STARTING ? 2'h3 : ag == AGENT_RUNNING ?
            2'h2 : {1'b0, ag == AGENT_CONNECTED};
        e[L_PWR_GREEN] = pw == PWR_BOOT ? 2'h2 : {1'b0, pw == PWR_RUNNING};
        e[L_PWR_RED] = {1'b0, pw == PWR_OFF};
        if (c[C_HALT])
        begin
            e = '0;
            e[L_HEALTH] = 2'h2;
        end
        return e;
    endfunction

    function automatic logic [1:0] seen_code(input logic l,
        input logic [4:0] f);
        return f === 5'h00 ? {1'b0, l} : f === 5'h04 ? 2'h2 :
            f === 5'h02 ? 2'h3 : 2'bxx;
    endfunction

    task automatic run_case(input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic [31:0] m;
        logic [13:0][1:0] e;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        cur = 18'(({14'h0, cur} & ~m) | (d & m)) & COND_MASK;
        wb(1'b1, COND_OFFSET, d, s, r);
        e = exp_codes(cur);
        repeat (2) @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (16) @(posedge clk_i);
        #1;
        for (int i = 0; i < LAMP_N; i++)
            chk_reg($sformatf("lamp %0d", i), 32'(e[i]),
                32'(seen_code(lamps[i], flips[i])));
        if (!cur[C_HALT] && !cur[C_SECURE_ERR] && cur[C_HW_UPDATE])
            chk_reg("in phase", 32'h0, {31'h0, sb});
        if (!cur[C_HALT] && cur[C_SECURE_ERR])
            chk_reg("alternate", 32'h0, {31'h0, ab});
        $display("case %h done", cur);
    endtask

    initial
    begin
        logic [31:0] r;
        void'($urandom(32257));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_reg("reset lamps", 32'h0, {18'h0, lamps});
        run_case(32'h00000, 4'hF);
        run_case(32'h3FFFF, 4'hF);
        run_case(32'h000C2, 4'hF);
        run_case(32'h00083, 4'hF);
        for (int k = 0; k < 4; k++)
            run_case({14'h0, 2'(3 - k), 2'h0, 2'(k), 12'h595}, 4'hF);
        for (int k = 0; k < 24; k++)
            run_case($urandom & (k < 16 ? 32'hFFFFFFDF : 32'hFFFFFFFF),
                k < 16 ? 4'hF : 4'($urandom));
        wb(1'b1, LAMP_OFFSET, 32'hFFFFFFFF, 4'hF, r);
        wb(1'b0, COND_OFFSET, 32'h0, 4'hF, r);
        chk_reg("lamp write ignored", {14'h0, cur}, r);
        wb(1'b0, 8'h08, 32'h0, 4'hF, r);
        chk_reg("unmapped read", 32'h0, r);
        run_case(32'h30595, 4'hF);
        wb(1'b0, LAMP_OFFSET, 32'h0, 4'hF, r);
        chk_reg("lamp readback", 32'h00002175, r & 32'h00003FFF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk_reg("reset lamps", 32'h0, {18'h0, lamps});
        wb(1'b0, COND_OFFSET, 32'h0, 4'hF, r);
        chk_reg("reset cond", 32'h0, r);
        test_done();
    end

    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        test_done();
    end
endmodule
`default_nettype wire
